// >>> shared/cmg_pkg.sv
package cmg_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;

  // Control one fields
  localparam int CTRL1_HG_POS     = 7;
  localparam int CTRL1_RANGE_POS  = 6;
  localparam int CTRL1_REFSEL_POS = 5;
  localparam int CTRL1_REQ_POS    = 3;

  // Control two fields
  localparam int CTRL2_MULT_POS = 4;
  localparam int CTRL2_DIV_POS  = 0;

  // Status fields
  localparam int STAT_MODE_POS    = 0;
  localparam int STAT_LOSS_POS    = 2;
  localparam int STAT_LOCK_POS    = 3;
  localparam int STAT_EXTOK_POS   = 4;
  localparam int STAT_OSCOK_POS   = 5;
  localparam int STAT_REFLOCK_POS = 6;

  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;

  // Status update delay in bus cycles
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  // Loop arithmetic
  localparam logic [2:0] IRG_PREDIV  = 3'h7;
  localparam logic [2:0] EXT_PREDIV  = 3'h1;
  localparam logic [6:0] P_RANGE_LOW = 7'h40;
  localparam logic [6:0] P_RANGE_HI  = 7'h01;
  localparam logic [4:0] N_BASE      = 5'h04;
  localparam logic [2:0] PNR_MIN     = 3'h4;
  localparam logic [8:0] FIXED_DIV   = 9'h002;

  typedef enum logic [1:0] {
    MODE_SELF     = 2'b00,
    MODE_LOOP_INT = 2'b01,
    MODE_BYPASS   = 2'b10,
    MODE_LOOP_EXT = 2'b11
  } cmg_mode_e;

  typedef struct packed {
    logic [2:0]  ref_prediv;
    logic [10:0] mult;
    logic [7:0]  r_div;
  } cmg_loop_cfg_s;

endpackage

// >>> rtl/cmg_decode.sv
`timescale 1ns/1ps
module cmg_decode (
  // Selections
  input  wire logic [2:0]  mult_sel,
  input  wire logic [2:0]  div_sel,
  input  wire logic        range_hi,
  // Decoded factors
  output logic      [4:0]  n_fac,
  output logic      [7:0]  r_fac,
  output logic      [10:0] pn_fac,
  output logic             pnr_ok
);
  logic [6:0] p_fac;

  assign n_fac  = cmg_pkg::N_BASE + {1'b0, mult_sel, 1'b0};
  assign r_fac  = 8'h01 << div_sel;
  assign p_fac  = range_hi ? cmg_pkg::P_RANGE_HI : cmg_pkg::P_RANGE_LOW;
  assign pn_fac = 11'(p_fac) * 11'(n_fac);
  assign pnr_ok = pn_fac >= 11'(r_fac) * 11'(cmg_pkg::PNR_MIN);
endmodule // cmg_decode

// >>> rtl/cmg_clkdiv.sv
`timescale 1ns/1ps
module cmg_clkdiv (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Source and factor
  input  wire logic       src,
  input  wire logic [8:0] factor,
  // Divided clock
  output logic            out_clk
);
  logic       src_q;
  logic [8:0] cnt_q;
  logic       edge_seen;

  assign edge_seen = src != src_q;

  // Sample source level
  always_ff @(posedge clk)
  begin
    if (srst)
      src_q <= 1'b0;
    else
      src_q <= src;
  end

  // Toggle every factor half periods
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q   <= 9'h000;
      out_clk <= 1'b0;
    end
    else if (edge_seen)
    begin
      if (cnt_q >= factor - 9'h001)
      begin
        cnt_q   <= 9'h000;
        out_clk <= ~out_clk;
      end
      else
        cnt_q <= cnt_q + 9'h001;
    end
  end
endmodule // cmg_clkdiv

// >>> rtl/cmg_top.sv
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Request field selects mode; status field reports actual mode, same encoding.
// - Status follows request once entry conditions of requested mode hold.
// - Loop modes need stable oscillator, external modes need good reference.
// - Status updates several bus cycles after a request change.
// - First control write without crystal request locks reference select low.
// - Self-clocked output is loop oscillator over R; reference still compared.
// - Loop external output is oscillator over 2R until locked, then over R.
// - Bypass output is external reference over R.
// - Loop internal uses internal reference over seven, times 64 and N.
// - Loop external uses external reference times P and N, over R.
// - Range zero gives P of 64, range one gives P of 1.
// - Multiplier N is four plus twice the select value.
// - Divider R is two to the power of the select value.
// - Fixed clock equals bus clock in bypass mode, and in loop external mode unless ratio and lock allow.
// - Loop external fixed clock is reference over two when ratio and lock allow.
// - Fixed clock is off in loop internal and self-clocked modes.
// - High gain applies to both ranges, valid only with reference select set.
// - High gain select is written only once after reset.
// - Clock loss flag is sticky until acknowledged or reset.
module cmg_top (
  // Clock and reset
  input  wire logic                   CLK_SYS,
  input  wire logic                   SRST,
  // Register port
  input  wire logic [7:0]             ADDR,
  input  wire logic [7:0]             WDATA,
  input  wire logic                   WR_STB,
  input  wire logic                   RD_STB,
  output logic      [7:0]             RDATA,
  // Clock sources
  input  wire logic                   OSC_LOOP_CLK,
  input  wire logic                   EXT_REF_CLK,
  input  wire logic                   BUS_CLK,
  // Monitor inputs
  input  wire logic                   EXT_REF_OK,
  input  wire logic                   LOOP_OSC_STABLE,
  input  wire logic                   LOOP_LOCKED,
  input  wire logic                   CLOCK_LOSS,
  input  wire logic                   GEN_OFF,
  // Clock outputs
  output logic                        GEN_OUT_CLK,
  output logic                        FIXED_CLK,
  output logic                        FIXED_CLK_ON,
  // Oscillator and loop control
  output logic                        AMP_EN,
  output logic                        HIGH_GAIN,
  output logic                        REF_FROM_EXT,
  output cmg_pkg::cmg_loop_cfg_s      LOOP_CFG,
  output logic      [1:0]             MODE_STATUS
);

  // Control state
  logic                hg_q;
  logic                hg_done_q;
  logic                range_q;
  logic                refsel_q;
  logic                ref_lock_q;
  logic                first_done_q;
  logic [1:0]          req_q;
  logic [2:0]          mult_sel_q;
  logic [2:0]          div_sel_q;
  logic                loss_q;
  logic                lock_seen_q;
  cmg_pkg::cmg_mode_e  mode_q;
  cmg_pkg::cmg_mode_e  tgt_q;
  logic [2:0]          settle_q;

  // Combinational terms
  logic                wr_ctrl1;
  logic                wr_ctrl2;
  logic                wr_stat;
  logic                refsel_eff;
  cmg_pkg::cmg_mode_e  tgt_mode;
  logic [4:0]          n_fac;
  logic [7:0]          r_fac;
  logic [10:0]         pn_fac;
  logic                pnr_ok;
  logic [8:0]          out_factor;
  logic                gen_src;
  logic                gen_div;
  logic                ref_half;
  logic [7:0]          rd_mux;

  assign wr_ctrl1   = WR_STB && ADDR == cmg_pkg::ADDR_CTRL1;
  assign wr_ctrl2   = WR_STB && ADDR == cmg_pkg::ADDR_CTRL2;
  assign wr_stat    = WR_STB && ADDR == cmg_pkg::ADDR_STAT;
  assign refsel_eff = refsel_q & ~ref_lock_q;

  // Mode that current request and monitors allow
  function automatic cmg_pkg::cmg_mode_e next_mode(
    input logic [1:0]         req,
    input cmg_pkg::cmg_mode_e cur,
    input logic               ext_ok,
    input logic               osc_ok,
    input logic               loss
  );
    cmg_pkg::cmg_mode_e nxt;
    nxt = cmg_pkg::MODE_SELF;
    case (req)
      2'b01:   nxt = osc_ok ? cmg_pkg::MODE_LOOP_INT : cmg_pkg::MODE_SELF;
      2'b10:   nxt = ext_ok ? cmg_pkg::MODE_BYPASS : cmg_pkg::MODE_SELF;
      2'b11:
      begin
        if (cur == cmg_pkg::MODE_BYPASS && loss && ext_ok)
          nxt = cmg_pkg::MODE_BYPASS;
        else if (ext_ok && osc_ok)
          nxt = cmg_pkg::MODE_LOOP_EXT;
        else if (cur == cmg_pkg::MODE_LOOP_INT && osc_ok)
          nxt = cmg_pkg::MODE_LOOP_INT;
        else
          nxt = cmg_pkg::MODE_SELF;
      end
      default: nxt = cmg_pkg::MODE_SELF;
    endcase
    return nxt;
  endfunction

  assign tgt_mode = next_mode(req_q, mode_q, EXT_REF_OK, LOOP_OSC_STABLE, loss_q);

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      first_done_q <= 1'b0;
      ref_lock_q   <= 1'b0;
    end
    else if (wr_ctrl1 && !first_done_q)
    begin
      first_done_q <= 1'b1;
      ref_lock_q   <= !(WDATA[cmg_pkg::CTRL1_REFSEL_POS] && WDATA[cmg_pkg::CTRL1_REQ_POS+1]);
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      hg_q      <= cmg_pkg::CTRL1_RST[cmg_pkg::CTRL1_HG_POS];
      hg_done_q <= 1'b0;
    end
    else if (wr_ctrl1 && !hg_done_q)
    begin
      hg_q      <= WDATA[cmg_pkg::CTRL1_HG_POS];
      hg_done_q <= 1'b1;
    end
  end

  // Control one fields; request held while off
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      range_q  <= cmg_pkg::CTRL1_RST[cmg_pkg::CTRL1_RANGE_POS];
      refsel_q <= cmg_pkg::CTRL1_RST[cmg_pkg::CTRL1_REFSEL_POS];
      req_q    <= cmg_pkg::CTRL1_RST[cmg_pkg::CTRL1_REQ_POS+:2];
    end
    else if (wr_ctrl1)
    begin
      range_q  <= WDATA[cmg_pkg::CTRL1_RANGE_POS];
      refsel_q <= WDATA[cmg_pkg::CTRL1_REFSEL_POS];
      if (!GEN_OFF)
        req_q <= WDATA[cmg_pkg::CTRL1_REQ_POS+:2];
    end
  end

  // Control two fields
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      mult_sel_q <= cmg_pkg::CTRL2_RST[cmg_pkg::CTRL2_MULT_POS+:3];
      div_sel_q  <= cmg_pkg::CTRL2_RST[cmg_pkg::CTRL2_DIV_POS+:3];
    end
    else if (wr_ctrl2)
    begin
      mult_sel_q <= WDATA[cmg_pkg::CTRL2_MULT_POS+:3];
      div_sel_q  <= WDATA[cmg_pkg::CTRL2_DIV_POS+:3];
    end
  end

  // sticky loss flag, set beats clear
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      loss_q <= 1'b0;
    else if (CLOCK_LOSS)
      loss_q <= 1'b1;
    else if (wr_stat && WDATA[cmg_pkg::STAT_LOSS_POS])
      loss_q <= 1'b0;
  end

  // status waits for a stable target
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      mode_q   <= cmg_pkg::MODE_SELF;
      tgt_q    <= cmg_pkg::MODE_SELF;
      settle_q <= 3'h0;
    end
    else
    begin
      tgt_q <= tgt_mode;
      if (GEN_OFF || tgt_mode == mode_q || tgt_mode != tgt_q)
        settle_q <= 3'h0;
      else if (settle_q == cmg_pkg::SETTLE_CYCLES - 3'h1)
      begin
        mode_q   <= tgt_mode;
        settle_q <= 3'h0;
      end
      else
        settle_q <= settle_q + 3'h1;
    end
  end

  // first lock and relock after multiplier change
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      lock_seen_q <= 1'b0;
    else if (mode_q != cmg_pkg::MODE_LOOP_EXT || (wr_ctrl2 && WDATA[cmg_pkg::CTRL2_MULT_POS+:3] != mult_sel_q))
      lock_seen_q <= 1'b0;
    else if (LOOP_LOCKED)
      lock_seen_q <= 1'b1;
  end

  cmg_decode u_decode (
    .mult_sel (mult_sel_q),
    .div_sel  (div_sel_q),
    .range_hi (range_q),
    .n_fac    (n_fac),
    .r_fac    (r_fac),
    .pn_fac   (pn_fac),
    .pnr_ok   (pnr_ok)
  );

  assign out_factor = (mode_q == cmg_pkg::MODE_LOOP_EXT && !lock_seen_q) ? {r_fac, 1'b0} : {1'b0, r_fac};
  assign gen_src    = (mode_q == cmg_pkg::MODE_BYPASS) ? EXT_REF_CLK : OSC_LOOP_CLK;

  cmg_clkdiv u_gen_div (
    .clk     (CLK_SYS),
    .srst    (SRST),
    .src     (gen_src),
    .factor  (out_factor),
    .out_clk (gen_div)
  );

  cmg_clkdiv u_fixed_div (
    .clk     (CLK_SYS),
    .srst    (SRST),
    .src     (EXT_REF_CLK),
    .factor  (cmg_pkg::FIXED_DIV),
    .out_clk (ref_half)
  );

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      GEN_OUT_CLK <= 1'b0;
    else
      GEN_OUT_CLK <= GEN_OFF ? 1'b0 : gen_div;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      FIXED_CLK    <= 1'b0;
      FIXED_CLK_ON <= 1'b0;
    end
    else if (mode_q == cmg_pkg::MODE_SELF || mode_q == cmg_pkg::MODE_LOOP_INT)
    begin
      FIXED_CLK    <= 1'b0;
      FIXED_CLK_ON <= 1'b0;
    end
    else
    begin
      FIXED_CLK_ON <= 1'b1;
      if (mode_q == cmg_pkg::MODE_LOOP_EXT && pnr_ok && LOOP_LOCKED)
        FIXED_CLK <= ref_half;
      else
        FIXED_CLK <= BUS_CLK;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      LOOP_CFG     <= '0;
      REF_FROM_EXT <= 1'b0;
    end
    else
    begin
      REF_FROM_EXT    <= mode_q == cmg_pkg::MODE_LOOP_EXT;
      LOOP_CFG.r_div  <= r_fac;
      if (mode_q == cmg_pkg::MODE_LOOP_EXT)
      begin
        LOOP_CFG.ref_prediv <= cmg_pkg::EXT_PREDIV;
        LOOP_CFG.mult       <= pn_fac;
      end
      else
      begin
        LOOP_CFG.ref_prediv <= cmg_pkg::IRG_PREDIV;
        LOOP_CFG.mult       <= {n_fac, 6'h00};
      end
    end
  end

  // oscillator controls gated by reference select
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      AMP_EN    <= 1'b0;
      HIGH_GAIN <= 1'b0;
    end
    else
    begin
      AMP_EN    <= refsel_eff && req_q[1];
      HIGH_GAIN <= refsel_eff && hg_q;
    end
  end

  assign MODE_STATUS = mode_q;

  // Read data mux
  always_comb
  begin
    rd_mux = 8'h00;
    case (ADDR)
      cmg_pkg::ADDR_CTRL1: rd_mux = {hg_q, range_q, refsel_eff, req_q, 3'h0};
      cmg_pkg::ADDR_CTRL2: rd_mux = {1'b0, mult_sel_q, 1'b0, div_sel_q};
      cmg_pkg::ADDR_STAT:  rd_mux = {1'b0, ref_lock_q, LOOP_OSC_STABLE, EXT_REF_OK, LOOP_LOCKED, loss_q, mode_q};
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      RDATA <= 8'h00;
    else
      RDATA <= RD_STB ? rd_mux : 8'h00;
  end

  // Checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  sequence s_target_held;
    !GEN_OFF && tgt_mode != mode_q && $stable(tgt_mode);
  endsequence

  sequence s_bad_first_write;
    wr_ctrl1 && !first_done_q && !(WDATA[5] && WDATA[4]);
  endsequence

  a_status_follows: assert property (s_target_held [*4] |=> mode_q == $past(tgt_mode))
    else $error("status did not follow request");
  a_status_delayed: assert property ($changed(mode_q) |-> $past(settle_q) == 3'h3)
    else $error("status changed without settle delay");
  a_loop_needs_osc: assert property (req_q[0] && !LOOP_OSC_STABLE && mode_q != cmg_pkg::MODE_BYPASS
    |-> tgt_mode == cmg_pkg::MODE_SELF)
    else $error("loop mode without stable oscillator");
  a_bypass_hold: assert property (req_q == 2'b11 && mode_q == cmg_pkg::MODE_BYPASS && loss_q && EXT_REF_OK
    |-> tgt_mode == cmg_pkg::MODE_BYPASS)
    else $error("bypass left during clock loss");
  a_ref_locked: assert property (s_bad_first_write ##1 1'b1 |-> ref_lock_q [*8])
    else $error("reference select not locked");
  a_hg_once: assert property (hg_done_q && wr_ctrl1 |=> $stable(hg_q))
    else $error("high gain rewritten");
  a_hg_gated: assert property (!refsel_eff |=> !HIGH_GAIN)
    else $error("high gain without reference select");
  a_prelock_div: assert property (mode_q == cmg_pkg::MODE_LOOP_EXT && !lock_seen_q
    |-> out_factor == {r_fac, 1'b0})
    else $error("initial lock divide wrong");
  a_fixed_off: assert property (mode_q == cmg_pkg::MODE_SELF || mode_q == cmg_pkg::MODE_LOOP_INT
    |=> !FIXED_CLK && !FIXED_CLK_ON)
    else $error("fixed clock running in internal mode");
  a_loss_sticky: assert property (CLOCK_LOSS |=> loss_q ##1 (loss_q || $past(wr_stat)))
    else $error("clock loss flag not held");
  a_off_low: assert property (GEN_OFF |=> !GEN_OUT_CLK)
    else $error("output clock running while off");

endmodule // cmg_top

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  // Clock and reset
  logic                   CLK_SYS;
  logic                   SRST;
  // Register port
  logic [7:0]             ADDR;
  logic [7:0]             WDATA;
  logic                   WR_STB;
  logic                   RD_STB;
  logic [7:0]             RDATA;
  // Sources and monitors
  logic                   OSC_LOOP_CLK;
  logic                   EXT_REF_CLK;
  logic                   BUS_CLK;
  logic                   EXT_REF_OK;
  logic                   LOOP_OSC_STABLE;
  logic                   LOOP_LOCKED;
  logic                   CLOCK_LOSS;
  logic                   GEN_OFF;
  // Outputs
  logic                   GEN_OUT_CLK;
  logic                   FIXED_CLK;
  logic                   FIXED_CLK_ON;
  logic                   AMP_EN;
  logic                   HIGH_GAIN;
  logic                   REF_FROM_EXT;
  cmg_pkg::cmg_loop_cfg_s LOOP_CFG;
  logic [1:0]             MODE_STATUS;
  // Bench state
  logic [2:0]             div_q;
  logic [7:0]             d;
  int                     c;
  int                     err_total;
  int                     checks;

  cmg_top i_dut (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
    .RDATA(RDATA), .OSC_LOOP_CLK(OSC_LOOP_CLK), .EXT_REF_CLK(EXT_REF_CLK), .BUS_CLK(BUS_CLK),
    .EXT_REF_OK(EXT_REF_OK), .LOOP_OSC_STABLE(LOOP_OSC_STABLE), .LOOP_LOCKED(LOOP_LOCKED),
    .CLOCK_LOSS(CLOCK_LOSS), .GEN_OFF(GEN_OFF), .GEN_OUT_CLK(GEN_OUT_CLK), .FIXED_CLK(FIXED_CLK),
    .FIXED_CLK_ON(FIXED_CLK_ON), .AMP_EN(AMP_EN), .HIGH_GAIN(HIGH_GAIN), .REF_FROM_EXT(REF_FROM_EXT),
    .LOOP_CFG(LOOP_CFG), .MODE_STATUS(MODE_STATUS)
  );

  always #25 CLK_SYS = ~CLK_SYS;

  // Source clocks: reference and loop toggle each cycle, bus every four
  always @(posedge CLK_SYS)
  begin
    EXT_REF_CLK  <= ~EXT_REF_CLK;
    OSC_LOOP_CLK <= ~OSC_LOOP_CLK;
    div_q        <= div_q + 3'h1;
    BUS_CLK      <= div_q[2];
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR   <= a;
    WDATA  <= v;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR   <= a;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    #1;
    v = RDATA;
  endtask

  task automatic do_reset();
    @(posedge CLK_SYS);
    SRST <= 1'b1;
    repeat (20) @(posedge CLK_SYS);
    SRST <= 1'b0;
  endtask

  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 20 && MODE_STATUS !== m; i++) cycles(1);
  endtask

  // Counts level changes of the output or the fixed clock over 64 cycles
  task automatic toggles(input bit fixed, output int n);
    logic prev;
    logic now;
    n = 0;
    cycles(1);
    prev = fixed ? FIXED_CLK : GEN_OUT_CLK;
    repeat (64)
    begin
      cycles(1);
      now = fixed ? FIXED_CLK : GEN_OUT_CLK;
      if (now !== prev) n++;
      prev = now;
    end
  endtask

  task automatic near(input int n, input int e);
    chk(32'(n >= e - 2 && n <= e + 2), 32'h1);
  endtask

  task automatic t_reset();
    rd(cmg_pkg::ADDR_CTRL1, d); chk(d, cmg_pkg::CTRL1_RST);
    rd(cmg_pkg::ADDR_CTRL2, d); chk(d, cmg_pkg::CTRL2_RST);
    rd(8'h0C, d); chk(d, 8'h00);
    chk(MODE_STATUS, 2'h0); // self-clocked after reset
    $display("test reset done");
  endtask

  task automatic t_lock();
    wr(cmg_pkg::ADDR_CTRL1, 8'h08);
    cycles(10); chk(MODE_STATUS, 2'h0); // oscillator not stable
    rd(cmg_pkg::ADDR_STAT, d); chk(d[6], 1'b1); // reference locked low
    LOOP_OSC_STABLE <= 1'b1;
    cycles(2); chk(MODE_STATUS, 2'h0); // no immediate update
    wait_mode(2'h1); chk(MODE_STATUS, 2'h1); // loop internal reached
    chk(FIXED_CLK_ON, 1'b0); // fixed clock off, peripherals keep off it
    wr(cmg_pkg::ADDR_CTRL2, 8'h30);
    cycles(3); chk(LOOP_CFG, {3'h7, 11'h280, 8'h01}); // internal ref arithmetic
    wr(cmg_pkg::ADDR_CTRL1, 8'h38);
    rd(cmg_pkg::ADDR_CTRL1, d); chk(d, 8'h18); // select stays low
    chk(AMP_EN, 1'b0); // amplifier kept off
    $display("test lock done");
  endtask

  task automatic t_crystal();
    do_reset();
    wr(cmg_pkg::ADDR_CTRL1, 8'hB8);
    rd(cmg_pkg::ADDR_CTRL1, d); chk(d, 8'hB8); // crystal request kept
    chk(HIGH_GAIN, 1'b1); // high gain on
    chk(AMP_EN, 1'b1); // amplifier enabled
    wr(cmg_pkg::ADDR_CTRL1, 8'h38);
    rd(cmg_pkg::ADDR_CTRL1, d); chk(d, 8'hB8); // high gain of second write ignored
    chk(HIGH_GAIN, 1'b1); // gain unchanged
    cycles(10); chk(MODE_STATUS, 2'h0); // reference not good
    $display("test crystal done");
  endtask

  task automatic t_bypass();
    EXT_REF_OK <= 1'b1;
    wr(cmg_pkg::ADDR_CTRL1, 8'hB0);
    wait_mode(2'h2); chk(MODE_STATUS, 2'h2); // bypass reached
    cycles(1); chk(FIXED_CLK_ON, 1'b1); // fixed clock present
    cycles(4); toggles(1'b0, c); near(c, 64); // reference over one
    wr(cmg_pkg::ADDR_CTRL2, 8'h02);
    cycles(8); toggles(1'b0, c); near(c, 16); // reference over four
    toggles(1'b1, c); near(c, 16); // follows bus clock
    $display("test bypass done");
  endtask

  task automatic t_loss();
    @(posedge CLK_SYS);
    CLOCK_LOSS <= 1'b1;
    @(posedge CLK_SYS);
    CLOCK_LOSS <= 1'b0;
    rd(cmg_pkg::ADDR_STAT, d); chk(d[2], 1'b1); // flag set
    wr(cmg_pkg::ADDR_CTRL1, 8'hB8);
    cycles(10); chk(MODE_STATUS, 2'h2); // stays bypass on loss
    rd(cmg_pkg::ADDR_STAT, d); chk(d[2], 1'b1); // flag sticky
    wr(cmg_pkg::ADDR_STAT, 8'h04);
    rd(cmg_pkg::ADDR_STAT, d); chk(d[2], 1'b0); // flag acknowledged
    wait_mode(2'h3); chk(MODE_STATUS, 2'h3); // loop external reached
    $display("test loss done");
  endtask

  task automatic t_loopext();
    wr(cmg_pkg::ADDR_CTRL2, 8'h00);
    cycles(8); toggles(1'b0, c); near(c, 32); // halved before lock
    toggles(1'b1, c); near(c, 16); // bus clock when unlocked
    LOOP_LOCKED <= 1'b1;
    cycles(8); toggles(1'b0, c); near(c, 64); // full rate after lock
    toggles(1'b1, c); near(c, 32); // reference over two
    for (int r = 0; r < 2; r++)
    begin
      wr(cmg_pkg::ADDR_CTRL1, r ? 8'hF8 : 8'hB8);
      for (int m = 0; m < 8; m++)
      begin
        for (int v = 0; v < 8; v++)
        begin
          wr(cmg_pkg::ADDR_CTRL2, 8'((m << 4) | v));
          cycles(3);
          chk(32'(LOOP_CFG.mult), (r ? 1 : 64) * (4 + 2 * m)); // multiplier
          chk(32'(LOOP_CFG.r_div), 1 << v); // divider
        end
      end
    end
    chk(LOOP_CFG.ref_prediv, 3'h1); // external reference undivided
    chk(REF_FROM_EXT, 1'b1); // loop uses external reference
    $display("test loop external done");
  endtask

  task automatic t_off();
    GEN_OFF <= 1'b1;
    cycles(2);
    wr(cmg_pkg::ADDR_CTRL1, 8'hB0);
    cycles(10); chk(MODE_STATUS, 2'h3); // request ignored
    rd(cmg_pkg::ADDR_CTRL1, d); chk(d[4:3], 2'h3); // field unchanged
    toggles(1'b0, c); chk(c, 0); // output clock still
    chk(GEN_OUT_CLK, 1'b0); // output held low
    $display("test off done");
  endtask

  initial
  begin
    repeat (20000) @(posedge CLK_SYS);
    err_total++;
    $display("watchdog expired");
    close_out();
  end

  initial
  begin
    CLK_SYS         = 1'b0;
    SRST            = 1'b1;
    ADDR            = 8'h00;
    WDATA           = 8'h00;
    WR_STB          = 1'b0;
    RD_STB          = 1'b0;
    OSC_LOOP_CLK    = 1'b0;
    EXT_REF_CLK     = 1'b0;
    BUS_CLK         = 1'b0;
    EXT_REF_OK      = 1'b0;
    LOOP_OSC_STABLE = 1'b0;
    LOOP_LOCKED     = 1'b0;
    CLOCK_LOSS      = 1'b0;
    GEN_OFF         = 1'b0;
    div_q           = 3'h0;
    err_total       = 0;
    checks          = 0;
    do_reset();
    t_reset();
    t_lock();
    t_crystal();
    t_bypass();
    t_loss();
    t_loopext();
    t_off();
    close_out();
  end
endmodule // tb
